// ---- lbs_pkg.sv ----
// package for the limit bin sorter: register map, fields, types
package lbs_pkg;
  localparam int DW = 32;
  localparam int NBIN = 9;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_REF = 8'h08;
  localparam logic [7:0] A_STEP = 8'h0C;
  localparam logic [7:0] A_MEAS_P = 8'h10;
  localparam logic [7:0] A_MEAS_S = 8'h14;
  localparam logic [7:0] A_RESULT = 8'h18;
  localparam logic [7:0] A_RES_P = 8'h1C;
  localparam logic [7:0] A_RES_S = 8'h20;
  localparam logic [7:0] A_SEC_LO = 8'h24;
  localparam logic [7:0] A_SEC_HI = 8'h28;
  localparam logic [7:0] A_BIN_LO = 8'h40;
  localparam logic [7:0] A_BIN_HI = 8'h80;
  localparam logic [7:0] A_CNT = 8'hC0;
  localparam int CTRL_COMP = 0;
  localparam int CTRL_AUX = 1;
  localparam int CTRL_SEC_EN = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CTRL_BIN_EN_LSB = 8;
  localparam int CMD_CLEAR = 0;
  localparam int CMD_FINE_UP = 1;
  localparam int CMD_FINE_DN = 2;
  localparam int CMD_COARSE_UP = 3;
  localparam int CMD_COARSE_DN = 4;
  localparam int CMD_CNT_CLR = 5;
  localparam logic [31:0] REF_RST = 32'h0000_0000;
  localparam logic [31:0] SEC_HI_RST = 32'h0000_0000;
  localparam logic [3:0] STEP_RST = 4'h0;
  localparam logic [8:0] BIN_EN_RST = 9'h000;
  localparam logic [31:0] LIM_RST = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [31:0] HUNDRED = 32'h0000_0064;
  localparam logic [3:0] CAT_NONE = 4'hF;
  localparam logic [3:0] CAT_NOMATCH = 4'h9;
  localparam logic [3:0] CAT_AUX = 4'hA;
  localparam int NCAT = 11;
  typedef enum logic [1:0] {
    LBS_ABS = 2'h0,
    LBS_DABS = 2'h1,
    LBS_DPCT = 2'h2
  } lbs_mode_e;
  typedef struct packed {
    logic        valid;
    logic [31:0] prim;
    logic [31:0] sec;
  } lbs_meas_s;
  typedef struct packed {
    logic       valid;
    logic       pass;
    logic [3:0] cat;
  } lbs_judge_s;
endpackage

// ---- lbs_cnt_mem.sv ----
// per-category counter memory with registered read data
module lbs_cnt_mem #(
  parameter int DEPTH = 11,
  parameter int AW    = 4
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          clr,
  input  wire logic          inc,
  input  wire logic [AW-1:0] inc_addr,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [31:0]   rd_data
);
  logic [31:0] mem_reg [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cnt
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          mem_reg[g] <= 32'h0000_0000;
        end else if (clr) begin
          mem_reg[g] <= 32'h0000_0000;
        end else if (inc && inc_addr == AW'(g)) begin
          mem_reg[g] <= mem_reg[g] + 32'h0000_0001;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h0000_0000;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data <= mem_reg[rd_addr];
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end
endmodule

// ---- lbs_sorter.sv ----
// limit bin sorter: limit table, judgment, handler outputs, avalon slave
// Contract
// - nine enabled primary ranges, one secondary
// - result is one of eleven categories
// - bin one alone gives pass/fail
// - limits absolute or deviation from reference
// - modes: absolute, abs deviation, percent
// - secondary range always compared absolute
// - result to handler and readable with value
// - one counter per category, readable
// - comparator off disables handler outputs
// - table clear restores bin and secondary enables, limits, mode, reference
// - reference fine or coarse step up/down
// - overlapping matches pick lowest bin
// - upper not above lower means disabled
// - secondary fail: aux bin or no match
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
module lbs_sorter #(
  parameter int NBIN = lbs_pkg::NBIN
) (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire lbs_pkg::lbs_meas_s     meas,
  output lbs_pkg::lbs_judge_s         judge,
  output logic      [NBIN-1:0]        hdl_bin,
  output logic                        hdl_no_match_category,
  output logic                        hdl_aux,
  output logic                        hdl_valid,
  output logic                        hdl_oe
);
  logic                      comp_reg;
  logic                      aux_reg;
  logic                      sec_en_reg;
  lbs_pkg::lbs_mode_e        mode_reg;
  logic [NBIN-1:0]           bin_en_reg;
  logic [31:0]               ref_reg;
  logic [3:0]                step_reg;
  logic signed [31:0]        lo_reg [NBIN];
  logic signed [31:0]        hi_reg [NBIN];
  logic signed [31:0]        sec_lo_reg;
  logic signed [31:0]        sec_hi_reg;
  logic [31:0]               res_p_reg;
  logic [31:0]               res_s_reg;
  logic                      ack_reg;
  logic [31:0]               rd_reg;
  logic [31:0]               cnt_rd;
  logic [31:0]               wmask;
  logic                      wr;
  logic                      clear;
  logic [31:0]               coarse;
  logic [NBIN-1:0]           hit;
  logic [3:0]                cat_next;
  logic                      sec_ok;
  logic                      cnt_rd_sel;
  logic [31:0]               cmd;

  // writes commit at the edge that ends the wait
  assign wr = avs_write && ack_reg;
  assign cmd = (wr && avs_address == lbs_pkg::A_CMD) ? avs_writedata : 32'h0000_0000;
  assign clear = cmd[lbs_pkg::CMD_CLEAR];
  assign cnt_rd_sel = avs_address >= lbs_pkg::A_CNT;

  // every access answered on the second cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  // coarse step choices 1,2,5,10,20,50,100,200,500
  always_comb begin
    case (step_reg)
      4'h0: coarse = 32'h0000_0001;
      4'h1: coarse = 32'h0000_0002;
      4'h2: coarse = 32'h0000_0005;
      4'h3: coarse = 32'h0000_000A;
      4'h4: coarse = 32'h0000_0014;
      4'h5: coarse = 32'h0000_0032;
      4'h6: coarse = 32'h0000_0064;
      4'h7: coarse = 32'h0000_00C8;
      4'h8: coarse = 32'h0000_01F4;
      default: coarse = 32'h0000_0001;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // control register: comparator, aux, secondary enable, mode, bin enables
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      comp_reg <= 1'b0;
      aux_reg <= 1'b0;
      sec_en_reg <= 1'b0;
      mode_reg <= lbs_pkg::LBS_ABS;
      bin_en_reg <= '0;
    end else if (clear) begin
      sec_en_reg <= 1'b0;
      mode_reg <= lbs_pkg::LBS_ABS;
      bin_en_reg <= '0;
    end else if (wr && avs_address == lbs_pkg::A_CTRL) begin
      if (avs_byteenable[0]) begin
        comp_reg <= avs_writedata[lbs_pkg::CTRL_COMP];
        aux_reg <= avs_writedata[lbs_pkg::CTRL_AUX];
        sec_en_reg <= avs_writedata[lbs_pkg::CTRL_SEC_EN];
        case (avs_writedata[lbs_pkg::CTRL_MODE_LSB +: 2])
          2'h1: mode_reg <= lbs_pkg::LBS_DABS;
          2'h2: mode_reg <= lbs_pkg::LBS_DPCT;
          default: mode_reg <= lbs_pkg::LBS_ABS;
        endcase
      end
      if (avs_byteenable[1] && avs_byteenable[2]) begin
        bin_en_reg <= avs_writedata[lbs_pkg::CTRL_BIN_EN_LSB +: NBIN];
      end
    end
  end

  // reference value and step selection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_reg <= lbs_pkg::REF_RST;
      step_reg <= lbs_pkg::STEP_RST;
    end else if (clear) begin
      ref_reg <= lbs_pkg::REF_RST;
    end else if (wr && avs_address == lbs_pkg::A_REF) begin
      ref_reg <= (ref_reg & ~wmask) | (avs_writedata & wmask);
    end else if (wr && avs_address == lbs_pkg::A_STEP) begin
      step_reg <= avs_writedata[3:0];
    end else if (cmd[lbs_pkg::CMD_FINE_UP]) begin
      ref_reg <= ref_reg + 32'h0000_0001;
    end else if (cmd[lbs_pkg::CMD_FINE_DN]) begin
      ref_reg <= ref_reg - 32'h0000_0001;
    end else if (cmd[lbs_pkg::CMD_COARSE_UP]) begin
      ref_reg <= ref_reg + coarse;
    end else if (cmd[lbs_pkg::CMD_COARSE_DN]) begin
      ref_reg <= ref_reg - coarse;
    end
  end

  // limit table, one entry per bin
  genvar g;
  generate
    for (g = 0; g < NBIN; g++) begin : g_bin
      logic signed [31:0] eff_lo;
      logic signed [31:0] eff_hi;
      logic signed [63:0] p_lo;
      logic signed [63:0] p_hi;

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          lo_reg[g] <= lbs_pkg::LIM_RST;
          hi_reg[g] <= lbs_pkg::LIM_RST;
        end else if (clear) begin
          lo_reg[g] <= lbs_pkg::LIM_RST;
          hi_reg[g] <= lbs_pkg::LIM_RST;
        end else if (wr && avs_address == lbs_pkg::A_BIN_LO + 8'(4 * g)) begin
          lo_reg[g] <= (lo_reg[g] & ~wmask) | (avs_writedata & wmask);
        end else if (wr && avs_address == lbs_pkg::A_BIN_HI + 8'(4 * g)) begin
          hi_reg[g] <= (hi_reg[g] & ~wmask) | (avs_writedata & wmask);
        end
      end

      // effective limits per designation mode
      always_comb begin
        p_lo = (signed'({32'h0000_0000, ref_reg}) * (64'(signed'(lbs_pkg::HUNDRED)) +
                64'(lo_reg[g]))) / 64'sd100;
        p_hi = (signed'({32'h0000_0000, ref_reg}) * (64'(signed'(lbs_pkg::HUNDRED)) +
                64'(hi_reg[g]))) / 64'sd100;
        case (mode_reg)
          lbs_pkg::LBS_DABS: begin
            eff_lo = signed'(ref_reg) + lo_reg[g];
            eff_hi = signed'(ref_reg) + hi_reg[g];
          end
          lbs_pkg::LBS_DPCT: begin
            eff_lo = p_lo[31:0];
            eff_hi = p_hi[31:0];
          end
          default: begin
            eff_lo = lo_reg[g];
            eff_hi = hi_reg[g];
          end
        endcase
      end

      assign hit[g] = bin_en_reg[g] && (hi_reg[g] > lo_reg[g]) &&
                      (signed'(meas.prim) >= eff_lo) && (signed'(meas.prim) <= eff_hi);
    end
  endgenerate

  // secondary limits, always absolute
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sec_lo_reg <= lbs_pkg::LIM_RST;
      sec_hi_reg <= lbs_pkg::SEC_HI_RST;
    end else if (clear) begin
      sec_lo_reg <= lbs_pkg::LIM_RST;
      sec_hi_reg <= lbs_pkg::SEC_HI_RST;
    end else if (wr && avs_address == lbs_pkg::A_SEC_LO) begin
      sec_lo_reg <= (sec_lo_reg & ~wmask) | (avs_writedata & wmask);
    end else if (wr && avs_address == lbs_pkg::A_SEC_HI) begin
      sec_hi_reg <= (sec_hi_reg & ~wmask) | (avs_writedata & wmask);
    end
  end

  assign sec_ok = !sec_en_reg ||
                  ((signed'(meas.sec) >= sec_lo_reg) && (signed'(meas.sec) <= sec_hi_reg));

  // lowest matching bin wins
  always_comb begin
    cat_next = lbs_pkg::CAT_NOMATCH;
    for (int i = NBIN - 1; i >= 0; i--) begin
      if (hit[i]) begin
        cat_next = 4'(i);
      end
    end
    if (cat_next != lbs_pkg::CAT_NOMATCH && !sec_ok) begin
      cat_next = aux_reg ? lbs_pkg::CAT_AUX : lbs_pkg::CAT_NOMATCH;
    end
  end

  // judgment and captured measurement
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      judge <= '{valid: 1'b0, pass: 1'b0, cat: lbs_pkg::CAT_NONE};
      res_p_reg <= 32'h0000_0000;
      res_s_reg <= 32'h0000_0000;
    end else begin
      judge.valid <= meas.valid && comp_reg;
      if (meas.valid && comp_reg) begin
        judge.cat <= cat_next;
        judge.pass <= cat_next == 4'h0;
        res_p_reg <= meas.prim;
        res_s_reg <= meas.sec;
      end
    end
  end

  // handler outputs gated by comparator enable
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hdl_bin <= '0;
      hdl_no_match_category <= 1'b0;
      hdl_aux <= 1'b0;
      hdl_valid <= 1'b0;
      hdl_oe <= 1'b0;
    end else begin
      hdl_oe <= comp_reg;
      if (!comp_reg) begin
        hdl_bin <= '0;
        hdl_no_match_category <= 1'b0;
        hdl_aux <= 1'b0;
        hdl_valid <= 1'b0;
      end else if (meas.valid) begin
        for (int i = 0; i < NBIN; i++) begin
          hdl_bin[i] <= cat_next == 4'(i);
        end
        hdl_no_match_category <= cat_next == lbs_pkg::CAT_NOMATCH;
        hdl_aux <= cat_next == lbs_pkg::CAT_AUX;
        hdl_valid <= 1'b1;
      end else begin
        hdl_valid <= 1'b0;
      end
    end
  end

  lbs_cnt_mem #(
    .DEPTH (lbs_pkg::NCAT),
    .AW    (4)
  ) u_cnt (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .clr      (cmd[lbs_pkg::CMD_CNT_CLR]),
    .inc      (meas.valid && comp_reg),
    .inc_addr (cat_next),
    .rd_addr  (avs_address[5:2]),
    .rd_data  (cnt_rd)
  );

  // read mux, registered on the request cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_reg <= lbs_pkg::RD_UNMAPPED;
    end else if (avs_read && !ack_reg) begin
      rd_reg <= lbs_pkg::RD_UNMAPPED;
      case (avs_address)
        lbs_pkg::A_CTRL: rd_reg <= {15'h0000, bin_en_reg, 3'h0, mode_reg, sec_en_reg,
                                    aux_reg, comp_reg};
        lbs_pkg::A_REF: rd_reg <= ref_reg;
        lbs_pkg::A_STEP: rd_reg <= {28'h000_0000, step_reg};
        lbs_pkg::A_RESULT: rd_reg <= {26'h000_0000, judge.valid, judge.pass, judge.cat};
        lbs_pkg::A_RES_P: rd_reg <= res_p_reg;
        lbs_pkg::A_RES_S: rd_reg <= res_s_reg;
        lbs_pkg::A_SEC_LO: rd_reg <= sec_lo_reg;
        lbs_pkg::A_SEC_HI: rd_reg <= sec_hi_reg;
        default: begin
          for (int i = 0; i < NBIN; i++) begin
            if (avs_address == lbs_pkg::A_BIN_LO + 8'(4 * i)) rd_reg <= lo_reg[i];
            if (avs_address == lbs_pkg::A_BIN_HI + 8'(4 * i)) rd_reg <= hi_reg[i];
          end
        end
      endcase
    end
  end

  // counters come from the memory, one cycle after the address
  assign avs_readdata = (cnt_rd_sel && avs_address < lbs_pkg::A_CNT + 8'h2C) ? cnt_rd : rd_reg;
endmodule

// ---- lbs_chk.sv ----
// checker for the limit bin sorter ports
module lbs_chk #(
  parameter int NBIN = lbs_pkg::NBIN
) (
  input wire logic                clk_sys,
  input wire logic                nrst,
  input wire logic [7:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire lbs_pkg::lbs_meas_s  meas,
  input wire lbs_pkg::lbs_judge_s judge,
  input wire logic [NBIN-1:0]     hdl_bin,
  input wire logic                hdl_no_match_category,
  input wire logic                hdl_aux,
  input wire logic                hdl_valid,
  input wire logic                hdl_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not in second cycle");
  judge_gate_a: assert property (
    meas.valid |=> judge.valid == hdl_oe) else $error("judge pulse not gated by comparator");
  no_spur_a: assert property (
    !meas.valid |=> !judge.valid && !hdl_valid) else $error("judge pulse without measurement");
  off_quiet_a: assert property (
    !hdl_oe |-> {hdl_bin, hdl_no_match_category, hdl_aux, hdl_valid} == '0)
    else $error("handler lines driven while comparator off");
  one_cat_a: assert property (
    hdl_valid |-> $onehot({hdl_bin, hdl_no_match_category, hdl_aux}))
    else $error("handler category not one-hot");
  cat_range_a: assert property (
    judge.valid |-> judge.cat <= lbs_pkg::CAT_AUX) else $error("category out of range");
  bin_map_a: assert property (
    hdl_valid && judge.cat < 4'h9 |-> hdl_bin == (NBIN'(1) << judge.cat))
    else $error("bin line does not match category");
  aux_map_a: assert property (
    hdl_valid |-> hdl_aux == (judge.cat == lbs_pkg::CAT_AUX)
      && hdl_no_match_category == (judge.cat == lbs_pkg::CAT_NOMATCH))
    else $error("aux or no-match line does not match category");
  pass_map_a: assert property (
    judge.valid |-> judge.pass == (judge.cat == 4'h0)) else $error("pass flag not bin one");
  cat_hold_a: assert property (
    !judge.valid |-> $stable(judge.cat)) else $error("category changed without judgment");
  cover property (hdl_valid && hdl_aux);
  cover property (hdl_valid && hdl_no_match_category);
  cover property (judge.valid && judge.pass);
endmodule

// ---- lbs_hdl_model.sv ----
// parts handler model: decodes sort lines, counts units
module lbs_hdl_model (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic [8:0] hdl_bin,
  input wire logic       hdl_no_match_category,
  input wire logic       hdl_aux,
  input wire logic       hdl_valid,
  input wire logic       hdl_oe,
  output logic     [3:0] cat,
  output int             n_seen
);
  always_comb begin
    cat = 4'hF;
    if (hdl_valid && hdl_oe) begin
      if (hdl_aux) cat = 4'hA;
      else if (hdl_no_match_category) cat = 4'h9;
      else for (int i = 0; i < 9; i++) if (hdl_bin[i]) cat = 4'(i);
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) n_seen <= 0;
    else if (hdl_valid && hdl_oe) n_seen <= n_seen + 1;
  end
endmodule

// ---- tb_limit_bin_sorter.sv ----
// self-checking bench for the limit bin sorter
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_limit_bin_sorter;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic [7:0]         avs_address = 8'h00;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  lbs_pkg::lbs_meas_s  meas = '0;
  lbs_pkg::lbs_judge_s judge;
  logic [8:0]         hdl_bin;
  logic               hdl_nm, hdl_aux, hdl_valid, hdl_oe;
  logic [3:0]         m_cat;
  int                 n_seen, err_count, n_compared, lo[9], hi[9], mode, rf, slo, shi, total;
  int                 exp_cnt[11];
  int                 steps[9] = '{1, 2, 5, 10, 20, 50, 100, 200, 500};
  logic [8:0]         en;
  logic               sen, aux;
  logic [31:0]        q;
  always #2.5 clk_sys = ~clk_sys;
  lbs_sorter u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .meas(meas), .judge(judge), .hdl_bin(hdl_bin), .hdl_no_match_category(hdl_nm),
    .hdl_aux(hdl_aux), .hdl_valid(hdl_valid), .hdl_oe(hdl_oe));
  lbs_hdl_model u_hdl (.clk_sys(clk_sys), .nrst(nrst), .hdl_bin(hdl_bin),
    .hdl_no_match_category(hdl_nm), .hdl_aux(hdl_aux), .hdl_valid(hdl_valid),
    .hdl_oe(hdl_oe), .cat(m_cat), .n_seen(n_seen));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      results();
    end else begin
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    bus(1'b1, a, 32'(d));
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic int eff(input int v);
    return (mode == 1) ? rf + v : (mode == 2) ? rf * (100 + v) / 100 : v;
  endfunction
  function automatic logic [3:0] exp_cat(input int p, input int s);
    logic [3:0] c;
    c = lbs_pkg::CAT_NOMATCH;
    for (int i = 8; i >= 0; i--) begin
      if (en[i] && hi[i] > lo[i] && p >= eff(lo[i]) && p <= eff(hi[i])) c = 4'(i);
    end
    if (sen && (s < slo || s > shi))
      c = (aux && c != lbs_pkg::CAT_NOMATCH) ? lbs_pkg::CAT_AUX : lbs_pkg::CAT_NOMATCH;
    return c;
  endfunction
  task automatic mtest(input int p, input int s, input logic on);
    logic [3:0] c;
    c = exp_cat(p, s);
    meas <= '{1'b1, 32'(p), 32'(s)};
    @(posedge clk_sys);
    meas.valid <= 1'b0;
    @(posedge clk_sys);
    `CHK(judge.valid, on)
    `CHK(hdl_oe, on)
    `CHK(m_cat, on ? c : 4'hF)
    if (on) begin
      `CHK(judge.cat, c)
      `CHK(judge.pass, c == 4'h0)
      exp_cnt[c]++;
      total++;
    end
  endtask
  initial begin
    void'($urandom(38442));
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    `CHK(judge.cat, lbs_pkg::CAT_NONE)
    rd(lbs_pkg::A_REF);
    `CHK(q, lbs_pkg::REF_RST)
    rd(8'h3C);
    `CHK(q, lbs_pkg::RD_UNMAPPED)
    wr(lbs_pkg::A_CTRL, 0);
    mtest(5, 0, 1'b0);
    $display("test reset and comparator off done");
    rf = int'(lbs_pkg::REF_RST);
    for (int i = 0; i < 9; i++) begin
      wr(lbs_pkg::A_STEP, i);
      wr(lbs_pkg::A_CMD, 1 << lbs_pkg::CMD_COARSE_UP);
      wr(lbs_pkg::A_CMD, 1 << lbs_pkg::CMD_FINE_DN);
      rf = rf + steps[i] - 1;
      rd(lbs_pkg::A_REF);
      `CHK(q, 32'(rf))
    end
    wr(lbs_pkg::A_CMD, 1 << lbs_pkg::CMD_COARSE_DN);
    wr(lbs_pkg::A_CMD, 1 << lbs_pkg::CMD_FINE_UP);
    rd(lbs_pkg::A_REF);
    `CHK(q, 32'(rf - 499))
    $display("test reference steps done");
    for (int it = 0; it < 30; it++) begin
      mode = $urandom_range(0, 2);
      rf = 100 * $urandom_range(1, 10);
      aux = 1'($urandom);
      sen = 1'($urandom);
      en = 9'($urandom);
      slo = int'($urandom_range(0, 20)) - 20;
      shi = $urandom_range(0, 20);
      wr(lbs_pkg::A_CTRL, {15'h0, en, 3'h0, 2'(mode), sen, aux, 1'b1});
      wr(lbs_pkg::A_REF, rf);
      wr(lbs_pkg::A_SEC_LO, slo);
      wr(lbs_pkg::A_SEC_HI, shi);
      for (int i = 0; i < 9; i++) begin
        lo[i] = int'($urandom_range(0, 60)) - 30;
        hi[i] = lo[i] + int'($urandom_range(0, 40)) - 5;
        wr(lbs_pkg::A_BIN_LO + 8'(4 * i), lo[i]);
        wr(lbs_pkg::A_BIN_HI + 8'(4 * i), hi[i]);
      end
      for (int k = 0; k < 8; k++)
        mtest(eff(int'($urandom_range(0, 80)) - 40), int'($urandom_range(0, 50)) - 25, 1'b1);
    end
    $display("test random sorting done");
    wr(lbs_pkg::A_CMD, 1 << lbs_pkg::CMD_CLEAR);
    en = lbs_pkg::BIN_EN_RST;
    mode = 0;
    sen = 1'b0;
    rd(lbs_pkg::A_CTRL);
    `CHK(q, {30'h0, aux, 1'b1})
    rd(lbs_pkg::A_REF);
    `CHK(q, lbs_pkg::REF_RST)
    rd(lbs_pkg::A_BIN_HI + 8'h20);
    `CHK(q, lbs_pkg::LIM_RST)
    rd(lbs_pkg::A_SEC_HI);
    `CHK(q, lbs_pkg::SEC_HI_RST)
    mtest(7, -3, 1'b1);
    `CHK(judge.cat, lbs_pkg::CAT_NOMATCH)
    rd(lbs_pkg::A_RES_P);
    `CHK(q, 32'h0000_0007)
    rd(lbs_pkg::A_RES_S);
    `CHK(q, 32'hFFFF_FFFD)
    $display("test table clear done");
    for (int c = 0; c < 11; c++) begin
      rd(lbs_pkg::A_CNT + 8'(4 * c));
      `CHK(q, 32'(exp_cnt[c]))
    end
    `CHK(n_seen, total)
    wr(lbs_pkg::A_CMD, 1 << lbs_pkg::CMD_CNT_CLR);
    rd(lbs_pkg::A_CNT + 8'h24);
    `CHK(q, 32'h0)
    $display("test counters done");
    results();
  end
endmodule

bind lbs_sorter lbs_chk #(.NBIN(NBIN)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas(meas),
  .judge(judge), .hdl_bin(hdl_bin), .hdl_no_match_category(hdl_no_match_category),
  .hdl_aux(hdl_aux), .hdl_valid(hdl_valid), .hdl_oe(hdl_oe));
